//--- hdl/lhb_alarm.sv
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Heating: saturated output must move PV by the band within the window.
// - Cooling: same check with output saturation senses reversed.
// - Hold loop evaluation in tuning, manual, stop or ramp unless input fault.
// - Reset, mode change or zero time/band restarts window, loop alarm off.
// - Set or correction change restarts window, loop alarm kept.
// - MV change, stop or tune start restarts window; standard off, latched kept.
// - Sensor break, over-range or under-range drives loop alarm on.
// - Loop break acts only for events whose mode selects it.
// - After tuning store twice integral as window, clamped 20 to 9999.
// - After tuning store twice integral as band, clamped per input kind.
// - Auto values held until input type change, retune or manual write.
// - Alarm reset input restarts the monitoring start point.
// - Sensor open alarm in its mode, standard or latched only.
// - Heater alarm when measured current is below the threshold.
// - Heater checked only while control output is on.
// - No current sample until on-time passes 250 ms, or 1 s remote.
// - Heater check never with a current-type control output.
// - Heater alarm option is standard or latched only.
// - Four alarm events per channel.
// - Current source address 0 local, 65 to 80 expansion, default 0.
// - Expansion switch 0 maps to 80, 1 to F map to 65 to 79.
// - Current input index 0 to 3 local, 0 to 7 expansion, default 0.
module lhb_alarm
  import lhb_pkg::*;
#(
  parameter int unsigned TICK_CYC_P = TICK_CYC,
  parameter int unsigned MIN_ON_CYC_P = MIN_ON_CYC,
  parameter int unsigned MIN_ON_EXP_CYC_P = MIN_ON_EXP_CYC
)(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [15:0] process_value_i,
  input wire logic mv_at_high_i,
  input wire logic mv_at_low_i,
  input wire logic cooling_mode_i,
  input wire logic analog_input_i,
  input wire logic auto_tune_i,
  input wire logic manual_ctrl_i,
  input wire logic ctrl_stop_i,
  input wire logic ramp_active_i,
  input wire logic sensor_open_i,
  input wire logic input_over_range_i,
  input wire logic input_under_range_i,
  input wire logic op_mode_change_i,
  input wire logic sv_change_i,
  input wire logic corr_change_i,
  input wire logic mv_change_i,
  input wire logic input_type_change_i,
  input wire logic tune_done_i,
  input wire logic [15:0] tune_integral_i,
  input wire logic alarm_reset_i,
  input wire logic ctrl_out_on_i,
  input wire logic current_output_i,
  input wire logic [35:0] ct_local_i,
  input wire logic [71:0] ct_exp_i,
  input wire logic [3:0] exp_addr_sw_i,
  output logic [NUM_EVT-1:0] alarm_o,
  output logic loop_break_alarm_o
);

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic wr_ph_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic [7:0] mode_bits_r;
  logic [NUM_EVT-1:0] latch_opt_r;
  logic sw_reset_r;
  logic [13:0] loop_time_r;
  logic [13:0] loop_band_r;
  logic [8:0] heater_thr_r;
  logic [6:0] ct_addr_r;
  logic [2:0] ct_in_r;
  logic [13:0] sec_cnt_r;
  logic loop_cond_r;
  logic heater_cond_r;
  logic [NUM_EVT-1:0] alarm_r;
  logic fault;
  logic src_ok;
  logic addr_take;
  logic wr_time;
  logic wr_band;

  assign addr_take = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_r;
  assign wr_time = wr_ph_r && (wr_addr_r == ADDR_LOOP_TIME);
  assign wr_band = wr_ph_r && (wr_addr_r == ADDR_LOOP_BAND);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wr_ph_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_ph_r <= addr_take && hwrite_i;
      wr_addr_r <= haddr_i[7:0];
    end
  end

  // Read data is latched in the address phase, so every access is zero-wait
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rdata_r <= 32'h0000_0000;
    else if (addr_take && !hwrite_i)
    begin
      case (haddr_i[7:0])
        ADDR_CFG: rdata_r <= {20'h00000, latch_opt_r, mode_bits_r};
        ADDR_LOOP_TIME: rdata_r <= {18'h00000, loop_time_r};
        ADDR_LOOP_BAND: rdata_r <= {18'h00000, loop_band_r};
        ADDR_HEATER_THR: rdata_r <= {23'h000000, heater_thr_r};
        ADDR_CT_SEL: rdata_r <= {21'h000000, ct_in_r, 1'b0, ct_addr_r};
        ADDR_STATUS: rdata_r <= {2'h0, sec_cnt_r, 8'h00, src_ok, fault,
                                 heater_cond_r, loop_cond_r, alarm_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      mode_bits_r <= 8'h00;
      latch_opt_r <= 4'h0;
      sw_reset_r <= 1'b0;
      heater_thr_r <= HEATER_THR_RST;
      ct_addr_r <= CT_ADDR_RST;
      ct_in_r <= CURRENT_INPUT_SELECT_RST;
    end
    else
    begin
      sw_reset_r <= wr_ph_r && (wr_addr_r == ADDR_CFG) && hwdata_i[CFG_RESET_BIT];
      if (wr_ph_r && (wr_addr_r == ADDR_CFG))
      begin
        mode_bits_r <= hwdata_i[7:0];
        latch_opt_r <= hwdata_i[CFG_LATCH_LSB +: NUM_EVT];
      end
      if (wr_ph_r && (wr_addr_r == ADDR_HEATER_THR))
        heater_thr_r <= hwdata_i[8:0];
      if (wr_ph_r && (wr_addr_r == ADDR_CT_SEL))
      begin
        ct_addr_r <= hwdata_i[6:0];
        ct_in_r <= hwdata_i[CURRENT_INPUT_SELECT_LSB +: 3];
      end
    end
  end

  // ------------------------------------------------------------
  // Window and band values, automatic after tuning
  // ------------------------------------------------------------
  function automatic logic [13:0] twice_clamp(input logic [15:0] ti,
                                              input logic [13:0] lo,
                                              input logic [13:0] hi);
    logic [16:0] d;
    d = {ti, 1'b0};
    if (d < {3'h0, lo})
      return lo;
    else if (d > {3'h0, hi})
      return hi;
    else
      return d[13:0];
  endfunction : twice_clamp

  // Tuning wins over a bus write in the same cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      loop_time_r <= LOOP_TIME_RST;
      loop_band_r <= LOOP_BAND_RST;
    end
    else if (input_type_change_i)
    begin
      loop_time_r <= LOOP_TIME_RST;
      loop_band_r <= analog_input_i ? BAND_A_MIN : LOOP_BAND_RST;
    end
    else if (tune_done_i)
    begin
      loop_time_r <= twice_clamp(tune_integral_i, TIME_AUTO_MIN, TIME_AUTO_MAX);
      loop_band_r <= analog_input_i ?
        twice_clamp(tune_integral_i, BAND_A_MIN, BAND_A_MAX) :
        twice_clamp(tune_integral_i, BAND_T_MIN, BAND_T_MAX);
    end
    else
    begin
      if (wr_time)
        loop_time_r <= hwdata_i[13:0];
      if (wr_band)
        loop_band_r <= hwdata_i[13:0];
    end
  end

  // ------------------------------------------------------------
  // Loop break engine
  // ------------------------------------------------------------
  logic stop_d_r;
  logic tune_d_r;
  logic reset_evt;
  logic restart_off;
  logic restart_keep;
  logic restart_std;
  logic suspend;
  logic sat_up;
  logic sat_dn;
  logic rise;
  logic fall;
  logic moved;
  logic win_restart;
  logic expired;
  logic tick;
  logic [CNT_W-1:0] tick_cnt_r;
  logic [15:0] ref_pv_r;

  assign fault = sensor_open_i || input_over_range_i || input_under_range_i;
  assign reset_evt = alarm_reset_i || sw_reset_r;
  assign restart_off = reset_evt || op_mode_change_i ||
                       (loop_time_r == 14'h0000) || (loop_band_r == 14'h0000);
  assign restart_keep = sv_change_i || corr_change_i;
  assign restart_std = mv_change_i || (ctrl_stop_i && !stop_d_r) ||
                       (auto_tune_i && !tune_d_r);
  assign suspend = (auto_tune_i || manual_ctrl_i || ctrl_stop_i || ramp_active_i)
                   && !fault;
  assign sat_up = cooling_mode_i ? mv_at_low_i : mv_at_high_i;
  assign sat_dn = cooling_mode_i ? mv_at_high_i : mv_at_low_i;
  assign rise = {1'b0, process_value_i} >= ({1'b0, ref_pv_r} + {3'h0, loop_band_r});
  assign fall = ({1'b0, process_value_i} + {3'h0, loop_band_r}) <= {1'b0, ref_pv_r};
  assign moved = (sat_up && rise) || (sat_dn && fall);
  assign win_restart = restart_off || restart_keep || restart_std || suspend ||
                       !(sat_up || sat_dn) || moved;
  assign expired = !win_restart && (sec_cnt_r >= loop_time_r);
  assign tick = (tick_cnt_r == CNT_W'(TICK_CYC_P - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      stop_d_r <= 1'b0;
      tune_d_r <= 1'b0;
    end
    else
    begin
      stop_d_r <= ctrl_stop_i;
      tune_d_r <= auto_tune_i;
    end
  end

  // Window start: reference PV and elapsed seconds restart together
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tick_cnt_r <= '0;
      sec_cnt_r <= 14'h0000;
      ref_pv_r <= 16'h0000;
    end
    else if (win_restart)
    begin
      tick_cnt_r <= '0;
      sec_cnt_r <= 14'h0000;
      ref_pv_r <= process_value_i;
    end
    else
    begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
      if (tick && (sec_cnt_r != 14'h3fff))
        sec_cnt_r <= sec_cnt_r + 14'h0001;
    end
  end

  // Input fault sets and wins over every clearing event
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      loop_cond_r <= 1'b0;
    else if (fault)
      loop_cond_r <= 1'b1;
    else if (restart_off)
      loop_cond_r <= 1'b0;
    else if (restart_std)
      loop_cond_r <= 1'b0;
    else if (restart_keep || suspend)
      loop_cond_r <= loop_cond_r;
    else if (expired)
      loop_cond_r <= 1'b1;
    else if (moved)
      loop_cond_r <= 1'b0;
  end

  assign loop_break_alarm_o = loop_cond_r;

  // ------------------------------------------------------------
  // Heater current measurement
  // ------------------------------------------------------------
  logic src_exp;
  logic [6:0] exp_target;
  logic [8:0] cur_sel;
  logic [CNT_W-1:0] on_cnt_r;
  logic [CNT_W-1:0] on_need;
  logic meas_ok;

  assign src_exp = (ct_addr_r != 7'h00);
  assign exp_target = (exp_addr_sw_i == 4'h0) ? CT_EXP_SW0 :
                      (CT_EXP_BASE + {3'h0, exp_addr_sw_i});
  assign src_ok = !src_exp || (ct_addr_r == exp_target);
  assign cur_sel = src_exp ? ct_exp_i[9*ct_in_r +: 9] :
                   ct_local_i[9*ct_in_r[1:0] +: 9];
  assign on_need = src_exp ? CNT_W'(MIN_ON_EXP_CYC_P) : CNT_W'(MIN_ON_CYC_P);
  assign meas_ok = ctrl_out_on_i && (on_cnt_r > on_need);

  // Short pulses leave the transformer reading unsettled, so they are skipped
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !ctrl_out_on_i)
      on_cnt_r <= '0;
    else if (on_cnt_r <= on_need)
      on_cnt_r <= on_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      heater_cond_r <= 1'b0;
    else
      heater_cond_r <= meas_ok && !current_output_i && src_ok &&
                       (heater_thr_r != 9'h000) && (cur_sel < heater_thr_r);
  end

  // ------------------------------------------------------------
  // Alarm events
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_EVT; g++)
    begin : g_evt
      logic [1:0] mode;
      logic cond;
      logic clr;
      logic latch_r;
      assign mode = mode_bits_r[2*g +: 2];
      assign cond = (mode == MODE_LOOP) ? loop_cond_r :
                    (mode == MODE_SENSOR) ? sensor_open_i :
                    (mode == MODE_HEATER) ? heater_cond_r : 1'b0;
      assign clr = (mode == MODE_LOOP) ? restart_off : reset_evt;
      // Set wins over clear in the same cycle
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
          latch_r <= 1'b0;
        else if (cond)
          latch_r <= 1'b1;
        else if (clr || (mode == MODE_OFF))
          latch_r <= 1'b0;
      end
      // Option bit offers only standard or latched behaviour
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
          alarm_r[g] <= 1'b0;
        else
          alarm_r[g] <= cond || (latch_opt_r[g] && latch_r && (mode != MODE_OFF));
      end
    end
  endgenerate

  assign alarm_o = alarm_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  AST_LOOP_FORCED_OFF: assert property (restart_off && !fault |=> !loop_cond_r)
    else $error("loop alarm not off after reset or zero setting");
  AST_FAULT_ON: assert property (fault |=> loop_cond_r && alarm_o[0] == 1'b0 ||
    loop_cond_r)
    else $error("loop alarm not on under input fault");
  AST_SUSPEND_HOLD: assert property (suspend && !loop_cond_r |=> !loop_cond_r)
    else $error("loop alarm raised while suspended");
  AST_KEEP_STATE: assert property (restart_keep && !fault && !restart_off &&
    !restart_std |=> $stable(loop_cond_r) && sec_cnt_r == 14'h0000)
    else $error("set change altered loop alarm");
  AST_STD_OFF: assert property (restart_std && !fault && !restart_off
    |=> !loop_cond_r ##0 tick_cnt_r == '0)
    else $error("standard loop alarm not cleared");
  AST_TIME_CLAMP: assert property (tune_done_i && !input_type_change_i
    |=> loop_time_r >= TIME_AUTO_MIN && loop_time_r <= TIME_AUTO_MAX)
    else $error("auto window out of range");
  AST_BAND_CLAMP: assert property (tune_done_i && !input_type_change_i &&
    !analog_input_i |=> loop_band_r >= BAND_T_MIN && loop_band_r <= BAND_T_MAX)
    else $error("auto band out of range");
  AST_HEATER_OFF: assert property (!ctrl_out_on_i || current_output_i
    |=> !heater_cond_r)
    else $error("heater flagged with output off");
  AST_RESET_RESTART: assert property (alarm_reset_i |=> sec_cnt_r == 14'h0000 &&
    ref_pv_r == $past(process_value_i))
    else $error("alarm reset did not restart window");
  AST_EXPIRE_SET: assert property (expired && !fault && !restart_keep && !suspend
    |=> loop_cond_r)
    else $error("expired window did not raise loop alarm");
  AST_MODE_OFF: assert property (mode_bits_r[1:0] == MODE_OFF |=> !alarm_o[0])
    else $error("event alarm on while disabled");

  COV_LOOP_EXPIRE: cover property (expired ##1 loop_cond_r);
  COV_HEATER_BREAK: cover property (heater_cond_r ##1 alarm_o != '0);
  COV_TUNE_STORE: cover property (tune_done_i ##1 loop_time_r != LOOP_TIME_RST);

endmodule : lhb_alarm
`default_nettype wire

//--- hdl/lhb_pkg.sv
package lhb_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
  localparam int unsigned MIN_ON_MS = 250;
  localparam int unsigned MIN_ON_CYC = MIN_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned MIN_ON_EXP_S = 1;
  localparam int unsigned MIN_ON_EXP_CYC = MIN_ON_EXP_S * CLK_HZ;
  localparam int CNT_W = 24;
  localparam int NUM_EVT = 4;

  // ------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_LOOP_TIME = 8'h04;
  localparam logic [7:0] ADDR_LOOP_BAND = 8'h08;
  localparam logic [7:0] ADDR_HEATER_THR = 8'h0c;
  localparam logic [7:0] ADDR_CT_SEL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int CFG_LATCH_LSB = 8;
  localparam int CFG_RESET_BIT = 16;
  localparam int CURRENT_INPUT_SELECT_LSB = 8;
  localparam int STAT_SEC_LSB = 16;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_LOOP = 2'h1;
  localparam logic [1:0] MODE_SENSOR = 2'h2;
  localparam logic [1:0] MODE_HEATER = 2'h3;

  // ------------------------------------------------------------
  // Reset values and automatic ranges
  // ------------------------------------------------------------
  localparam logic [13:0] LOOP_TIME_RST = 14'h0000;
  localparam logic [13:0] LOOP_BAND_RST = 14'h0014;
  localparam logic [8:0] HEATER_THR_RST = 9'h000;
  localparam logic [6:0] CT_ADDR_RST = 7'h00;
  localparam logic [2:0] CURRENT_INPUT_SELECT_RST = 3'h0;
  localparam logic [13:0] TIME_AUTO_MIN = 14'h0014;
  localparam logic [13:0] TIME_AUTO_MAX = 14'h270f;
  localparam logic [13:0] BAND_T_MIN = 14'h0014;
  localparam logic [13:0] BAND_T_MAX = 14'h03e8;
  localparam logic [13:0] BAND_A_MIN = 14'h0002;
  localparam logic [13:0] BAND_A_MAX = 14'h0064;
  localparam logic [6:0] CT_EXP_BASE = 7'h40;
  localparam logic [6:0] CT_EXP_SW0 = 7'h50;
endpackage : lhb_pkg

//--- testbench/lhb_ct_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Heater current transformers
// ------------------------------------------------------------
// One input carries the heater under test; every other input reads a healthy
// full load, so a wrong input selection shows up as a missing alarm.
module lhb_ct_model (
  input wire logic [8:0] load_i,
  input wire logic [2:0] idx_i,
  input wire logic exp_i,
  output logic [35:0] ct_local_o,
  output logic [71:0] ct_exp_o
);
  always_comb
  begin
    ct_local_o = {4{9'h1f4}};
    ct_exp_o = {8{9'h1f4}};
    if (exp_i)
      ct_exp_o[9*idx_i +: 9] = load_i;
    else
      ct_local_o[9*idx_i[1:0] +: 9] = load_i;
  end
endmodule : lhb_ct_model
`default_nettype wire

//--- testbench/test_lhb_alarm.sv
`timescale 1ns/1ps
`default_nettype none
module test_lhb_alarm
  import lhb_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic [6:0] addr;
    logic [2:0] idx;
    logic [3:0] sw;
    logic [8:0] cur;
    logic on;
    logic co;
    logic exp;
  } lhb_hrow_t;
  localparam int P_RST = 0;
  localparam int P_TYPE = 1;
  localparam int P_MV = 2;
  localparam int P_CORR = 3;
  localparam int P_SV = 4;
  localparam int P_OPM = 5;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:0] pv = 16'h0100;
  logic sat_hi = 1'b0;
  logic sat_lo = 1'b0;
  logic cool = 1'b0;
  logic analog = 1'b0;
  logic [3:0] susp = 4'h0;
  logic [2:0] fault = 3'h0;
  logic [5:0] pulse = 6'h0;
  logic tune_done = 1'b0;
  logic [15:0] tune_int = 16'h0;
  logic ct_on = 1'b0;
  logic cur_out = 1'b0;
  logic [8:0] load = 9'h0;
  logic [2:0] ct_idx = 3'h0;
  logic use_exp = 1'b0;
  logic [3:0] sw = 4'h0;
  logic [35:0] ct_local;
  logic [71:0] ct_exp;
  logic [3:0] alarm;
  logic loop_break_alarm;
  logic [31:0] rd;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] regs [6] = '{ADDR_CFG, ADDR_LOOP_TIME, ADDR_LOOP_BAND, ADDR_HEATER_THR,
                           ADDR_CT_SEL, 8'h18};
  logic [31:0] rvals [6] = '{32'h0, 32'h0, 32'h14, 32'h0, 32'h0, 32'h0};
  // Threshold is 25 (2.5 A); spare transformers read 50.0 A
  lhb_hrow_t rows [10] = '{
    '{7'h00, 3'h3, 4'h0, 9'h00a, 1'b1, 1'b0, 1'b1},
    '{7'h00, 3'h0, 4'h0, 9'h01e, 1'b1, 1'b0, 1'b0},
    '{7'h00, 3'h1, 4'h0, 9'h018, 1'b1, 1'b0, 1'b1},
    '{7'h00, 3'h1, 4'h0, 9'h019, 1'b1, 1'b0, 1'b0},
    '{7'h00, 3'h2, 4'h0, 9'h000, 1'b0, 1'b0, 1'b0},
    '{7'h00, 3'h2, 4'h0, 9'h000, 1'b1, 1'b1, 1'b0},
    '{7'h50, 3'h7, 4'h0, 9'h005, 1'b1, 1'b0, 1'b1},
    '{7'h41, 3'h4, 4'h1, 9'h005, 1'b1, 1'b0, 1'b1},
    '{7'h4f, 3'h0, 4'hf, 9'h005, 1'b1, 1'b0, 1'b1},
    '{7'h42, 3'h0, 4'h1, 9'h005, 1'b1, 1'b0, 1'b0}};

  always #50 clk_sys = ~clk_sys;

  lhb_ct_model u_ct (.load_i(load), .idx_i(ct_idx), .exp_i(use_exp), .ct_local_o(ct_local),
    .ct_exp_o(ct_exp));

  lhb_alarm #(.TICK_CYC_P(10), .MIN_ON_CYC_P(5), .MIN_ON_EXP_CYC_P(8)) dut (
    .clk_sys_i(clk_sys), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .process_value_i(pv),
    .mv_at_high_i(sat_hi), .mv_at_low_i(sat_lo), .cooling_mode_i(cool),
    .analog_input_i(analog), .auto_tune_i(susp[0]), .manual_ctrl_i(susp[1]),
    .ctrl_stop_i(susp[2]), .ramp_active_i(susp[3]), .sensor_open_i(fault[0]),
    .input_over_range_i(fault[1]), .input_under_range_i(fault[2]),
    .op_mode_change_i(pulse[P_OPM]), .sv_change_i(pulse[P_SV]), .corr_change_i(pulse[P_CORR]),
    .mv_change_i(pulse[P_MV]), .input_type_change_i(pulse[P_TYPE]), .tune_done_i(tune_done),
    .tune_integral_i(tune_int), .alarm_reset_i(pulse[P_RST]), .ctrl_out_on_i(ct_on),
    .current_output_i(cur_out), .ct_local_i(ct_local), .ct_exp_i(ct_exp),
    .exp_addr_sw_i(sw), .alarm_o(alarm), .loop_break_alarm_o(loop_break_alarm));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_reg

  task automatic chk_al(input logic [4:0] got, input logic [4:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_al

  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    rd = hrdata;
  endtask : bus

  // Lands 10 ns after the edge so registered outputs have settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : wait_n

  task automatic fire(input int k);
    @(posedge clk_sys);
    pulse[k] <= 1'b1;
    @(posedge clk_sys);
    pulse <= 6'h0;
  endtask : fire

  task automatic tune(input logic [15:0] v, input logic a, input logic [13:0] t,
                      input logic [13:0] b);
    @(posedge clk_sys);
    tune_int <= v;
    analog <= a;
    tune_done <= 1'b1;
    @(posedge clk_sys);
    tune_done <= 1'b0;
    bus(1'b0, ADDR_LOOP_TIME, 32'h0);
    chk_reg(rd, {18'h0, t}, "tuned window");
    bus(1'b0, ADDR_LOOP_BAND, 32'h0);
    chk_reg(rd, {18'h0, b}, "tuned band");
  endtask : tune

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    #(20000 * 100);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b1, 8'h18, 32'hffff_ffff);
    foreach (regs[i])
    begin
      bus(1'b0, regs[i], 32'h0);
      chk_reg(rd, rvals[i], "reset value");
    end
    chk_reg({31'h0, hresp}, 32'h0, "bus response okay");
    $display("test reset values done");
    bus(1'b1, ADDR_CFG, 32'h3);
    bus(1'b1, ADDR_HEATER_THR, 32'h19);
    foreach (rows[i])
    begin
      bus(1'b1, ADDR_CT_SEL, {21'h0, rows[i].idx, 1'b0, rows[i].addr});
      @(posedge clk_sys);
      sw <= rows[i].sw;
      load <= rows[i].cur;
      ct_idx <= rows[i].idx;
      use_exp <= (rows[i].addr != 7'h00);
      cur_out <= rows[i].co;
      ct_on <= rows[i].on;
      wait_n(4);
      chk_al({loop_break_alarm, alarm}, 5'h00, "before minimum on-time");
      wait_n(16);
      chk_al({loop_break_alarm, alarm}, {4'h0, rows[i].exp}, "heater row");
      @(posedge clk_sys);
      ct_on <= 1'b0;
      wait_n(4);
      chk_al({loop_break_alarm, alarm}, 5'h00, "output off");
    end
    $display("test heater table done");
    bus(1'b1, ADDR_CFG, 32'h27);
    bus(1'b1, ADDR_LOOP_TIME, 32'h3);
    @(posedge clk_sys);
    sat_hi <= 1'b1;
    wait_n(20);
    chk_al({loop_break_alarm, alarm}, 5'h00, "inside window");
    wait_n(25);
    chk_al({loop_break_alarm, alarm}, 5'h12, "heating saturated high");
    fire(P_SV);
    wait_n(3);
    chk_al({loop_break_alarm, alarm}, 5'h12, "setpoint change");
    fire(P_CORR);
    wait_n(3);
    chk_al({loop_break_alarm, alarm}, 5'h12, "correction change");
    fire(P_RST);
    wait_n(20);
    chk_al({loop_break_alarm, alarm}, 5'h00, "alarm reset restarts");
    wait_n(25);
    chk_al({loop_break_alarm, alarm}, 5'h12, "after restart");
    fire(P_OPM);
    wait_n(3);
    chk_al({loop_break_alarm, alarm}, 5'h00, "mode change");
    wait_n(45);
    bus(1'b1, ADDR_CFG, 32'h227);
    fire(P_MV);
    wait_n(3);
    chk_al({loop_break_alarm, alarm}, 5'h02, "latched kept on value change");
    bus(1'b1, ADDR_LOOP_TIME, 32'h0);
    wait_n(3);
    chk_al({loop_break_alarm, alarm}, 5'h00, "zero window");
    bus(1'b1, ADDR_CFG, 32'h27);
    bus(1'b1, ADDR_LOOP_TIME, 32'h3);
    @(posedge clk_sys);
    sat_hi <= 1'b0;
    sat_lo <= 1'b1;
    fire(P_RST);
    wait_n(45);
    chk_al({loop_break_alarm, alarm}, 5'h12, "heating saturated low");
    @(posedge clk_sys);
    cool <= 1'b1;
    fire(P_OPM);
    wait_n(45);
    chk_al({loop_break_alarm, alarm}, 5'h12, "cooling saturated low");
    bus(1'b1, ADDR_CFG, 32'h0001_0027);
    wait_n(3);
    chk_al({loop_break_alarm, alarm}, 5'h00, "register alarm reset");
    fire(P_RST);
    for (int s = 0; s < 5; s++)
    begin
      @(posedge clk_sys);
      pv <= pv + 16'd25;
      wait_n(14);
    end
    chk_al({loop_break_alarm, alarm}, 5'h00, "cooling with rising value");
    @(posedge clk_sys);
    cool <= 1'b0;
    sat_lo <= 1'b0;
    $display("test loop window done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_sys);
      sat_hi <= 1'b1;
      susp[k] <= 1'b1;
      fire(P_RST);
      wait_n(45);
      chk_al({loop_break_alarm, alarm}, 5'h00, "suspended");
      for (int j = 0; j < 3; j++)
      begin
        @(posedge clk_sys);
        fault[j] <= 1'b1;
        wait_n(3);
        chk_al({loop_break_alarm, alarm} & 5'h12, 5'h12, "input fault");
        if (j == 0)
          chk_al({loop_break_alarm, alarm} & 5'h04, 5'h04, "sensor open");
        @(posedge clk_sys);
        fault <= 3'h0;
        fire(P_RST);
        wait_n(3);
      end
      @(posedge clk_sys);
      susp <= 4'h0;
      sat_hi <= 1'b0;
    end
    $display("test suspension and faults done");
    tune(16'd5000, 1'b0, 14'h270f, 14'h03e8);
    tune(16'd3, 1'b0, 14'h0014, 14'h0014);
    tune(16'd30, 1'b1, 14'h003c, 14'h003c);
    tune(16'd1, 1'b1, 14'h0014, 14'h0002);
    tune(16'd60, 1'b1, 14'h0078, 14'h0064);
    fire(P_TYPE);
    bus(1'b0, ADDR_LOOP_TIME, 32'h0);
    chk_reg(rd, 32'h0, "input type change");
    tune(16'd100, 1'b0, 14'h00c8, 14'h00c8);
    bus(1'b1, ADDR_LOOP_TIME, 32'h7);
    bus(1'b0, ADDR_LOOP_BAND, 32'h0);
    chk_reg(rd, 32'hc8, "band kept on manual write");
    $display("test auto tuning done");
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, ADDR_LOOP_BAND, 32'h0);
    chk_reg(rd, 32'h14, "band after second reset");
    bus(1'b0, ADDR_CFG, 32'h0);
    chk_reg(rd, 32'h0, "config after second reset");
    $display("test second reset done");
    report_and_stop();
  end
endmodule : test_lhb_alarm
`default_nettype wire
